/* verilog/i2cs_pkg.sv */
`default_nettype none
package i2cs_pkg;
  // APB byte offsets
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_STAT = 12'h004;
  localparam logic [11:0] OFF_ADDR = 12'h008;
  localparam logic [11:0] OFF_RCV = 12'h00c;
  localparam logic [11:0] OFF_TRN = 12'h010;
  // Control register fields
  localparam int CTRL_ENABLE = 15;
  localparam int CTRL_CLK_RELEASE = 12;
  localparam int CTRL_ADDR_WIDTH = 10;
  localparam int CTRL_GEN_CALL = 7;
  localparam logic [15:0] CTRL_RESET = 16'h1000;
  // Status register fields; bits 5:0 read only
  localparam int STAT_RBF = 0;
  localparam int STAT_TBF = 1;
  localparam int STAT_RW = 2;
  localparam int STAT_FULL_TEN_BIT_MATCH_FLAG = 5;
  localparam int STAT_OV = 6;
  localparam int STAT_EVT = 7;
  localparam int STAT_RO_BITS = 6;
  localparam logic [15:0] STAT_RESET = 16'h0000;
  localparam logic [9:0] ADDR_RESET = 10'h000;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [4:0] TEN_BIT_PREFIX = 5'h1e;
  localparam logic [7:0] GEN_CALL_ADDR = 8'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] ACK_BIT = 4'h9;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_ACK = 3'h3,
    ST_RX = 3'h2,
    ST_ADDR2 = 3'h6,
    ST_TX_HOLD = 3'h7,
    ST_TX = 3'h5,
    ST_TX_ACK = 3'h4
  } i2cs_state_t;
endpackage
`default_nettype wire

/* verilog/i2cs_slave.sv */
// Function
// - Idle until start, then shift address byte
// - Control bit 10 selects 7/10-bit address
// - 7-bit: compare address bits, bit0 direction
// - Sample data on serial clock rising edge
// - Ack match, flag on ninth falling edge
// - Address match leaves receive buffer alone; general call stores its byte
// - Read: ack, then stretch clock until load
// - Release bit frees clock; shift on falls
// - Transmit flag on ninth fall regardless ack
// - Write: store byte and ack when allowed
// - Buffer full: nack, flag, drop byte
// - Overflow set, buffer empty: store but nack
// - 10-bit first byte matches 11110 plus high
// - First byte write: flag, clear match flag
// - Second byte matches low: flag, set flag
// - Any 10-bit mismatch clears flag, idles
// - Repeated start read needs only high byte
// - Receive and transmit both double buffered
// - Status low six read only; rest writable
// - General call enable matches all-zero address in 7-bit mode only
`timescale 1ns/10ps
`default_nettype none
module i2cs_slave (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n
);

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction

  // Pin synchronisers and agreement filter
  logic scl_s1_r, scl_s2_r, scl_s3_r, scl_f_r;
  logic sda_s1_r, sda_s2_r, sda_s3_r, sda_f_r;
  wire logic scl_agree = (scl_s2_r == scl_s3_r);
  wire logic sda_agree = (sda_s2_r == sda_s3_r);
  wire logic scl_rise = scl_agree & scl_s3_r & ~scl_f_r;
  wire logic scl_fall = scl_agree & ~scl_s3_r & scl_f_r;
  wire logic sda_rise = sda_agree & sda_s3_r & ~sda_f_r;
  wire logic sda_fall = sda_agree & ~sda_s3_r & sda_f_r;
  wire logic start_det = sda_fall & scl_f_r & ~scl_fall;
  wire logic stop_det = sda_rise & scl_f_r & ~scl_fall;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {scl_s1_r, scl_s2_r, scl_s3_r, scl_f_r} <= 4'hf;
      {sda_s1_r, sda_s2_r, sda_s3_r, sda_f_r} <= 4'hf;
    end else begin
      {scl_s1_r, scl_s2_r, scl_s3_r} <= {scl_i, scl_s1_r, scl_s2_r};
      {sda_s1_r, sda_s2_r, sda_s3_r} <= {sda_i, sda_s1_r, sda_s2_r};
      if (scl_agree) scl_f_r <= scl_s3_r;
      if (sda_agree) sda_f_r <= sda_s3_r;
    end
  end

  // Registers
  logic [15:0] ctrl_r, ctrl_nxt;
  logic [15:8] stat_hi_r;
  logic [9:0] own_addr_r;
  logic [7:0] rcv_r, rcv_nxt, trn_r, rsr_r, rsr_nxt, tsr_r, tsr_nxt;
  logic rbf_r, rbf_nxt, tbf_r, tbf_nxt, rw_r, rw_nxt, full_ten_bit_match_flag_r, full_ten_bit_match_flag_nxt;
  logic ov_r, ov_nxt, evt_r, evt_nxt, ack_r, ack_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  i2cs_pkg::i2cs_state_t st_r, st_nxt, ret_r, ret_nxt;

  // APB decode; zero wait states
  wire logic acc = psel & penable;
  wire logic wr = acc & pwrite;
  wire logic rd = acc & ~pwrite;
  wire logic setup_rd = psel & ~penable & ~pwrite;
  wire logic map_hit = hit(paddr, i2cs_pkg::OFF_CTRL) | hit(paddr, i2cs_pkg::OFF_STAT) |
                       hit(paddr, i2cs_pkg::OFF_ADDR) | hit(paddr, i2cs_pkg::OFF_RCV) |
                       hit(paddr, i2cs_pkg::OFF_TRN);
  wire logic wr_ctrl = wr & hit(paddr, i2cs_pkg::OFF_CTRL);
  wire logic wr_stat = wr & hit(paddr, i2cs_pkg::OFF_STAT);
  wire logic wr_addr = wr & hit(paddr, i2cs_pkg::OFF_ADDR);
  wire logic wr_trn = wr & hit(paddr, i2cs_pkg::OFF_TRN);
  wire logic rd_rcv = rd & hit(paddr, i2cs_pkg::OFF_RCV);
  wire logic [15:0] stat_view = {stat_hi_r[15:8], evt_r, ov_r, full_ten_bit_match_flag_r, 2'b00, rw_r, tbf_r, rbf_r};
  wire logic [15:0] rd_mux = hit(paddr, i2cs_pkg::OFF_CTRL) ? ctrl_r :
                             hit(paddr, i2cs_pkg::OFF_STAT) ? stat_view :
                             hit(paddr, i2cs_pkg::OFF_ADDR) ? {6'h00, own_addr_r} :
                             hit(paddr, i2cs_pkg::OFF_RCV) ? {8'h00, rcv_r} :
                             hit(paddr, i2cs_pkg::OFF_TRN) ? {8'h00, trn_r} : 16'h0000;
  assign pready = 1'b1;
  assign pslverr = acc & ~map_hit;

  wire logic enabled = ctrl_r[i2cs_pkg::CTRL_ENABLE];
  wire logic ten_bit = ctrl_r[i2cs_pkg::CTRL_ADDR_WIDTH];
  wire logic clock_release_bit = ctrl_r[i2cs_pkg::CTRL_CLK_RELEASE];

  // Address compare
  wire logic byte_done = scl_fall & (cnt_r == i2cs_pkg::BITS_PER_BYTE);
  wire logic ninth_fall = scl_fall & (cnt_r == i2cs_pkg::ACK_BIT);
  wire logic match7 = (rsr_r[7:1] == own_addr_r[6:0]);
  wire logic gen_call = ctrl_r[i2cs_pkg::CTRL_GEN_CALL] & (rsr_r == i2cs_pkg::GEN_CALL_ADDR);
  wire logic match10_hi = (rsr_r[7:3] == i2cs_pkg::TEN_BIT_PREFIX) & (rsr_r[2:1] == own_addr_r[9:8]);
  wire logic match10_lo = (rsr_r == own_addr_r[7:0]);
  wire logic in_shift = (st_r == i2cs_pkg::ST_ADDR) | (st_r == i2cs_pkg::ST_ADDR2) |
                        (st_r == i2cs_pkg::ST_RX);

  always_comb begin
    st_nxt = st_r;
    ret_nxt = ret_r;
    cnt_nxt = cnt_r;
    rsr_nxt = rsr_r;
    tsr_nxt = tsr_r;
    rcv_nxt = rcv_r;
    ack_nxt = ack_r;
    rw_nxt = rw_r;
    rbf_nxt = rbf_r & ~rd_rcv;
    tbf_nxt = tbf_r | wr_trn;
    full_ten_bit_match_flag_nxt = full_ten_bit_match_flag_r;
    ov_nxt = wr_stat ? pwdata[i2cs_pkg::STAT_OV] : ov_r;
    evt_nxt = wr_stat ? pwdata[i2cs_pkg::STAT_EVT] : evt_r;
    ctrl_nxt = wr_ctrl ? pwdata[15:0] : ctrl_r;
    if (in_shift && scl_rise && cnt_r < i2cs_pkg::BITS_PER_BYTE) begin
      rsr_nxt = {rsr_r[6:0], sda_f_r};
      cnt_nxt = cnt_r + 4'h1;
    end
    case (st_r)
      i2cs_pkg::ST_IDLE: begin
        cnt_nxt = 4'h0;
      end
      i2cs_pkg::ST_ADDR: begin
        if (byte_done) begin
          rw_nxt = rsr_r[0];
          st_nxt = i2cs_pkg::ST_ACK;
          ack_nxt = 1'b1;
          ret_nxt = rsr_r[0] ? i2cs_pkg::ST_TX_HOLD : i2cs_pkg::ST_RX;
          if (!ten_bit) begin
            if (gen_call) begin
              rcv_nxt = rsr_r;
              rbf_nxt = 1'b1;
            end else if (!match7) begin
              st_nxt = i2cs_pkg::ST_IDLE;
            end
          end else if (match10_hi && !rsr_r[0]) begin
            full_ten_bit_match_flag_nxt = 1'b0;
            ret_nxt = i2cs_pkg::ST_ADDR2;
          end else if (!(match10_hi && full_ten_bit_match_flag_r)) begin
            // Read with high byte only is a repeated start after full match
            full_ten_bit_match_flag_nxt = 1'b0;
            st_nxt = i2cs_pkg::ST_IDLE;
          end
        end
      end
      i2cs_pkg::ST_ADDR2: begin
        if (byte_done) begin
          if (match10_lo) begin
            full_ten_bit_match_flag_nxt = 1'b1;
            ack_nxt = 1'b1;
            st_nxt = i2cs_pkg::ST_ACK;
            ret_nxt = i2cs_pkg::ST_RX;
          end else begin
            full_ten_bit_match_flag_nxt = 1'b0;
            st_nxt = i2cs_pkg::ST_IDLE;
          end
        end
      end
      i2cs_pkg::ST_RX: begin
        if (byte_done) begin
          st_nxt = i2cs_pkg::ST_ACK;
          ret_nxt = i2cs_pkg::ST_RX;
          if (rbf_r) begin
            ack_nxt = 1'b0;
            ov_nxt = 1'b1;
          end else begin
            rcv_nxt = rsr_r;
            rbf_nxt = 1'b1;
            ack_nxt = ~ov_r;
          end
        end
      end
      i2cs_pkg::ST_ACK: begin
        if (scl_rise) cnt_nxt = i2cs_pkg::ACK_BIT;
        if (ninth_fall) begin
          evt_nxt = 1'b1;
          ack_nxt = 1'b0;
          cnt_nxt = 4'h0;
          st_nxt = ret_r;
          if (ret_r == i2cs_pkg::ST_TX_HOLD && !tbf_nxt) ctrl_nxt[i2cs_pkg::CTRL_CLK_RELEASE] = 1'b0;
        end
      end
      i2cs_pkg::ST_TX_HOLD: begin
        if (clock_release_bit && !scl_f_r) begin
          tsr_nxt = trn_r;
          tbf_nxt = wr_trn;
          cnt_nxt = 4'h0;
          st_nxt = i2cs_pkg::ST_TX;
        end
      end
      i2cs_pkg::ST_TX: begin
        if (scl_fall) begin
          tsr_nxt = {tsr_r[6:0], 1'b1};
          cnt_nxt = cnt_r + 4'h1;
          if (cnt_r == 4'h7) st_nxt = i2cs_pkg::ST_TX_ACK;
        end
      end
      i2cs_pkg::ST_TX_ACK: begin
        if (scl_rise) begin
          ack_nxt = ~sda_f_r;
          cnt_nxt = i2cs_pkg::ACK_BIT;
        end
        if (ninth_fall) begin
          evt_nxt = 1'b1;
          cnt_nxt = 4'h0;
          st_nxt = ack_r ? i2cs_pkg::ST_TX_HOLD : i2cs_pkg::ST_IDLE;
          ack_nxt = 1'b0;
          if (ack_r && !tbf_nxt) ctrl_nxt[i2cs_pkg::CTRL_CLK_RELEASE] = 1'b0;
        end
      end
      default: st_nxt = i2cs_pkg::ST_IDLE;
    endcase
    // Software setting the release bit beats the automatic clear
    if (wr_ctrl && pwdata[i2cs_pkg::CTRL_CLK_RELEASE]) ctrl_nxt[i2cs_pkg::CTRL_CLK_RELEASE] = 1'b1;
    // Bus conditions override any byte in flight
    if (start_det) begin
      st_nxt = i2cs_pkg::ST_ADDR;
      cnt_nxt = 4'h0;
      ack_nxt = 1'b0;
    end else if (stop_det) begin
      st_nxt = i2cs_pkg::ST_IDLE;
      ack_nxt = 1'b0;
    end
    if (!enabled) begin
      st_nxt = i2cs_pkg::ST_IDLE;
      ack_nxt = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= i2cs_pkg::ST_IDLE;
      ret_r <= i2cs_pkg::ST_IDLE;
      cnt_r <= 4'h0;
      {rsr_r, tsr_r, rcv_r} <= {3{i2cs_pkg::DATA_RESET}};
      {ack_r, rw_r, rbf_r, tbf_r, full_ten_bit_match_flag_r, ov_r, evt_r} <= 7'h00;
      ctrl_r <= i2cs_pkg::CTRL_RESET;
    end else begin
      st_r <= st_nxt;
      ret_r <= ret_nxt;
      cnt_r <= cnt_nxt;
      {rsr_r, tsr_r, rcv_r} <= {rsr_nxt, tsr_nxt, rcv_nxt};
      {ack_r, rw_r, rbf_r, tbf_r} <= {ack_nxt, rw_nxt, rbf_nxt, tbf_nxt};
      {full_ten_bit_match_flag_r, ov_r, evt_r} <= {full_ten_bit_match_flag_nxt, ov_nxt, evt_nxt};
      ctrl_r <= ctrl_nxt;
    end
  end

  // Plain software registers; status low bits ignore writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_hi_r <= i2cs_pkg::STAT_RESET[15:8];
      own_addr_r <= i2cs_pkg::ADDR_RESET;
      trn_r <= i2cs_pkg::DATA_RESET;
      prdata <= 32'h0000_0000;
    end else begin
      if (wr_stat) stat_hi_r <= pwdata[15:8];
      if (wr_addr) own_addr_r <= pwdata[9:0];
      if (wr_trn) trn_r <= pwdata[7:0];
      if (setup_rd) prdata <= {16'h0000, rd_mux};
    end
  end

  // Open drain: enable low pulls the line low, otherwise released
  wire logic drive_sda = ((st_r == i2cs_pkg::ST_ACK) & ack_r) | ((st_r == i2cs_pkg::ST_TX) & ~tsr_r[7]);
  // Held until the shifter is loaded, so bit 7 never moves while clock is high
  wire logic drive_scl = (st_r == i2cs_pkg::ST_TX_HOLD);
  assign sda_o = 1'b0;
  assign scl_o = 1'b0;
  assign sda_oe_n = ~drive_sda;
  assign scl_oe_n = ~drive_scl;

  // Checks
  sequence s_rx_done;
    (st_r == i2cs_pkg::ST_RX) && byte_done && !start_det && !stop_det && enabled;
  endsequence
  sequence s_ninth;
    (st_r == i2cs_pkg::ST_ACK || st_r == i2cs_pkg::ST_TX_ACK) && ninth_fall;
  endsequence

  a_evt_on_ninth: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(evt_r) && !$past(wr_stat) |-> $past(ninth_fall) && $past(st_r) inside {i2cs_pkg::ST_ACK, i2cs_pkg::ST_TX_ACK})
    else $error("event flag set outside ninth falling edge");
  a_ninth_sets_evt: assert property (@(posedge pclk) disable iff (!presetn)
    s_ninth |=> evt_r)
    else $error("ninth falling edge left event flag clear");
  a_full_nack: assert property (@(posedge pclk) disable iff (!presetn)
    s_rx_done ##0 rbf_r |=> !ack_r && ov_r && $stable(rcv_r))
    else $error("full buffer byte not refused");
  a_load_on_empty: assert property (@(posedge pclk) disable iff (!presetn)
    s_rx_done ##0 !rbf_r |=> rcv_r == $past(rsr_r) && rbf_r && ack_r == !$past(ov_r))
    else $error("byte not moved to holding buffer");
  a_addr_keeps_rcv: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r == i2cs_pkg::ST_ADDR) && byte_done && !gen_call |=> $stable(rcv_r) && $stable(rbf_r))
    else $error("address match touched receive buffer");
  a_shift_on_rise: assert property (@(posedge pclk) disable iff (!presetn)
    in_shift && scl_rise && cnt_r < 4'h8 && !start_det && enabled |=> rsr_r == {$past(rsr_r[6:0]), $past(sda_f_r)})
    else $error("data bit not shifted on clock rise");
  a_tx_stretch: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r == i2cs_pkg::ST_TX_HOLD) && !clock_release_bit |-> !scl_oe_n ##1 (st_r != i2cs_pkg::ST_TX))
    else $error("clock not held while waiting for data");
  a_ten_bit_full: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r == i2cs_pkg::ST_ADDR2) && byte_done && match10_lo && !start_det && !stop_det && enabled
    |=> full_ten_bit_match_flag_r && ack_r ##[1:1000] evt_r)
    else $error("second address byte match not flagged");
  a_ten_bit_fail: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r == i2cs_pkg::ST_ADDR2) && byte_done && !match10_lo && !start_det
    |=> !full_ten_bit_match_flag_r && st_r == i2cs_pkg::ST_IDLE)
    else $error("second address byte mismatch not dropped");
  a_idle_released: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == i2cs_pkg::ST_IDLE |-> sda_oe_n && scl_oe_n)
    else $error("line driven while idle");

endmodule // i2cs_slave
`default_nettype wire

/* verification/i2cs_master_model.sv */
`timescale 1ns/10ps
`default_nettype none
module i2cs_master_model (
  input wire logic scl,
  input wire logic sda,
  output logic scl_oe_n,
  output logic sda_oe_n
);
  // Sixth of a 300 ns bus bit
  localparam time Q = 50ns;
  initial begin
    scl_oe_n = 1'b1;
    sda_oe_n = 1'b1;
  end
  // Slow slaves may stretch; the bench timeout ends a stuck wait
  task automatic up();
    scl_oe_n = 1'b1;
    while (scl !== 1'b1) #5;
    #Q;
  endtask
  task automatic bit_io(input logic d, output logic s);
    // Slave moves data up to four clocks after a fall; keep clear of it
    #(2*Q);
    sda_oe_n = d;
    #Q;
    up();
    s = sda;
    #Q;
    scl_oe_n = 1'b0;
    #Q;
  endtask
  // Also serves as a repeated start
  task automatic start();
    sda_oe_n = 1'b1;
    #Q;
    up();
    sda_oe_n = 1'b0;
    #Q;
    scl_oe_n = 1'b0;
    #Q;
  endtask
  task automatic stop();
    sda_oe_n = 1'b0;
    #Q;
    up();
    sda_oe_n = 1'b1;
    #Q;
  endtask
  // Send d and sample the line, MSB first, then the ninth bit
  task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] q, output logic ao);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(ai, ao);
  endtask
endmodule // i2cs_master_model
`default_nettype wire

/* verification/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam logic [11:0] CTRL = i2cs_pkg::OFF_CTRL;
  localparam logic [11:0] STAT = i2cs_pkg::OFF_STAT;
  localparam logic [11:0] ADDR = i2cs_pkg::OFF_ADDR;
  localparam logic [11:0] RCV = i2cs_pkg::OFF_RCV;
  localparam logic [11:0] TRN = i2cs_pkg::OFF_TRN;
  localparam logic [31:0] EN = 32'h1 << i2cs_pkg::CTRL_ENABLE;
  localparam logic [31:0] REL = 32'h1 << i2cs_pkg::CTRL_CLK_RELEASE;
  localparam logic [31:0] A10 = 32'h1 << i2cs_pkg::CTRL_ADDR_WIDTH;
  localparam logic [31:0] GC = 32'h1 << i2cs_pkg::CTRL_GEN_CALL;
  localparam logic [31:0] EVT = 32'h1 << i2cs_pkg::STAT_EVT;
  localparam logic [31:0] FULL = 32'h1 << i2cs_pkg::STAT_RBF;
  localparam logic [31:0] DIR = 32'h1 << i2cs_pkg::STAT_RW;
  localparam logic [31:0] TEN = 32'h1 << i2cs_pkg::STAT_FULL_TEN_BIT_MATCH_FLAG;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, pe, scl_o, sda_o, s_scl_oe_n, s_sda_oe_n, m_scl_oe_n, m_sda_oe_n, a;
  logic [7:0] b;
  int fails = 0;
  int num_checks = 0;
  int cyc = 0;
  // Pull-ups: a line is low only while someone pulls it
  wire scl = s_scl_oe_n & m_scl_oe_n;
  wire sda = s_sda_oe_n & m_sda_oe_n;
  always #12.5 pclk = ~pclk;
  i2cs_slave uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_i(scl),
    .scl_o(scl_o), .scl_oe_n(s_scl_oe_n), .sda_i(sda), .sda_o(sda_o), .sda_oe_n(s_sda_oe_n));
  i2cs_master_model m (.scl(scl), .sda(sda), .scl_oe_n(m_scl_oe_n), .sda_oe_n(m_sda_oe_n));
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      summarize();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    pe = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rc(input logic [11:0] ad, input logic [31:0] e);
    apb(1'b0, ad, 32'h0);
    chk($sformatf("reg %h", ad), e, q);
  endtask
  // Filtered pins lag by a few clocks; let flags land
  task automatic mw(input logic [7:0] d, input logic e);
    m.xfer(d, 1'b1, b, a);
    chk("ack", {31'h0, e}, {31'h0, a});
    repeat (8) @(posedge pclk);
  endtask
  task automatic tx(input logic [7:0] e, input logic [31:0] c);
    fork
      m.xfer(8'hff, 1'b1, b, a);
      begin
        repeat (40) @(negedge pclk);
        chk("scl hold", 32'h0, {31'h0, s_scl_oe_n});
        apb(1'b1, TRN, {24'h0, e});
        apb(1'b1, CTRL, c);
      end
    join
    chk("tx byte", {24'h0, e}, {24'h0, b});
    repeat (8) @(posedge pclk);
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rc(CTRL, {16'h0, i2cs_pkg::CTRL_RESET});
    rc(STAT, {16'h0, i2cs_pkg::STAT_RESET});
    rc(ADDR, {22'h0, i2cs_pkg::ADDR_RESET});
    apb(1'b1, STAT, 32'hffff);
    rc(STAT, (32'hffff << i2cs_pkg::STAT_RO_BITS) & 32'hffff);
    apb(1'b1, STAT, 32'h0);
    apb(1'b0, 12'h020, 32'h0);
    chk("slverr", 32'h1, {31'h0, pe});
    chk("pin value", 32'h0, {30'h0, scl_o, sda_o});
    $display("test registers done");
    apb(1'b1, ADDR, 32'h52);
    apb(1'b1, CTRL, EN | REL);
    rc(CTRL, EN | REL);
    m.start();
    mw(8'ha4, 1'b0);
    rc(STAT, EVT);
    rc(RCV, 32'h0);
    apb(1'b1, STAT, 32'h0);
    mw(8'ha5, 1'b0);
    rc(STAT, EVT | FULL);
    mw(8'h3c, 1'b1);
    m.stop();
    m.start();
    mw(8'ha4, 1'b0);
    mw(8'h77, 1'b1);
    rc(RCV, 32'ha5);
    mw(8'h6e, 1'b1);
    m.stop();
    rc(RCV, 32'h6e);
    m.start();
    mw(8'ha6, 1'b1);
    m.stop();
    $display("test receive done");
    apb(1'b1, STAT, 32'h0);
    m.start();
    mw(8'ha5, 1'b0);
    tx(8'h96, EN | REL);
    rc(STAT, EVT | DIR);
    m.stop();
    $display("test transmit done");
    apb(1'b1, ADDR, 32'h2c5);
    apb(1'b1, CTRL, EN | REL | A10);
    apb(1'b1, STAT, 32'h0);
    m.start();
    mw(8'hf4, 1'b0);
    rc(STAT, EVT);
    mw(8'hc5, 1'b0);
    rc(STAT, EVT | TEN);
    m.start();
    mw(8'hf5, 1'b0);
    tx(8'h3b, EN | REL | A10);
    m.stop();
    m.start();
    mw(8'hf6, 1'b1);
    m.stop();
    apb(1'b0, STAT, 32'h0);
    chk("ten bit match", 32'h0, q & TEN);
    $display("test ten bit done");
    apb(1'b1, CTRL, EN | REL | GC);
    m.start();
    mw(8'h00, 1'b0);
    m.stop();
    rc(RCV, 32'h0);
    $display("test general call done");
    summarize();
  end
endmodule // tb
`default_nettype wire
